// ### silm_top.sv
`timescale 1ns/100ps
`include "silm_defs.svh"
// Operation
// - Momentary status bits are read-only, show live condition, writes ignored.
// - Sticky copies set by condition, held until software writes one.
// - Write-one clear fails while condition persists; bit sets again.
// - Each sticky bit has an enable; zero masks it from interrupt.
// - Interrupt held while any enabled sticky bit is set.
// - Four inputs active/LOS and holdover bits, each sticky with enable.
// - First PLL lock bit, one when locked, sticky with enable.
// - VCO calibration pending bit reads one until done, no sticky.
// - Reference valid bit; manual modes track the selected input.
// - Auto-hold: lost if selected input lost during holdover, or none valid; auto: none valid.
// - Lock output high only if synth locked and first locked or excluded.
// - Mask bit excludes first PLL lock from lock output.
// - First PLL bypass also excludes first PLL lock.
// - Deterministic delay only with first bypass 0 and synth bypass 1.
// - Reset loads all defaults, including sticky and enable bits.
// - Clock and sysref outputs disabled after reset until enabled.
module silm_top
  import silm_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] INPUT_ACTIVE,
  input wire logic FIRST_PLL_LOCKED,
  input wire logic SYNTH_PLL_LOCKED,
  input wire logic NOT_HOLDOVER,
  input wire logic VCO_CAL_PENDING,
  input wire logic [1:0] ACTIVE_INPUT_INDEX,
  output logic IRQ_OUT_N,
  output logic LOCK,
  output logic DETERMINISTIC,
  output logic [3:0] CLOCK_OUTPUTS_EN,
  output logic [3:0] SYSREF_OUTPUTS_EN,
  output logic IRQ
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] irq_enable;
    logic [7:0] config_bits;
    logic [7:0] out_en;
    logic [7:0] clr;
    logic [1:0] ev_stat;
    logic [1:0] ev_mask;
    logic irq_n;
    logic irq;
    logic determ;
  } silm_top_state_t;

  silm_top_state_t s_reg;
  silm_top_state_t s_next;
  silm_sticky_if sif ();
  logic lock_q;
  logic reference_valid_now;
  logic [7:0] momentary;
  logic [7:0] sticky_view;
  logic [7:0] status_word;
  logic [7:0] enabled_hits;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic any_inputs_valid;
  silm_mode_t mode;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE;
  assign rd = access && !PWRITE;
  assign mode = silm_mode_t'(s_reg.config_bits[`SILM_CFG_MODE_LSB +: 2]);
  assign any_inputs_valid = |INPUT_ACTIVE;

  always_comb begin
    reference_valid_now = 1'b1;
    case (mode)
      SILM_MODE_MANUAL, SILM_MODE_SHORT_HOLD: begin
        reference_valid_now = INPUT_ACTIVE[ACTIVE_INPUT_INDEX];
      end
      SILM_MODE_AUTO_HOLD: begin
        reference_valid_now = any_inputs_valid &&
          (INPUT_ACTIVE[ACTIVE_INPUT_INDEX] || NOT_HOLDOVER);
      end
      SILM_MODE_AUTO: begin
        reference_valid_now = any_inputs_valid;
      end
      default: begin
        reference_valid_now = 1'b1;
      end
    endcase
  end

  // Order: in0..in3, first lock, synth lock, not holdover, reference
  assign momentary = {reference_valid_now, NOT_HOLDOVER, SYNTH_PLL_LOCKED,
                      FIRST_PLL_LOCKED, INPUT_ACTIVE};
  assign sif.cond = momentary;
  assign sif.clr = s_reg.clr;
  assign sticky_view = sif.sticky;
  assign status_word = momentary;
  assign enabled_hits = sticky_view & s_reg.irq_enable;

  silm_sticky_bank u_bank (
    .clk(CLK),
    .rst(RST),
    .sif(sif)
  );

  silm_lock_gen u_lock (
    .clk(CLK),
    .rst(RST),
    .first_locked(FIRST_PLL_LOCKED),
    .synth_locked(SYNTH_PLL_LOCKED),
    .mask_first(s_reg.config_bits[`SILM_CFG_MASK_BIT]),
    .first_bypass(s_reg.config_bits[`SILM_CFG_FIRST_PLL_BYPASS_BIT]),
    .lock_q(lock_q)
  );

  always_comb begin
    s_next = s_reg;
    s_next.pready = setup;
    s_next.pslverr = 1'b0;
    s_next.clr = 8'h00;
    if (setup && !PWRITE) begin
      s_next.prdata = 32'h0000_0000;
      case (PADDR)
        `SILM_OFS_STATUS: s_next.prdata = {21'h000000, VCO_CAL_PENDING,
                                           ACTIVE_INPUT_INDEX, status_word};
        `SILM_OFS_STICKY: s_next.prdata = {24'h000000, sticky_view};
        `SILM_OFS_IRQ_EN: s_next.prdata = {24'h000000, s_reg.irq_enable};
        `SILM_OFS_CONFIG: s_next.prdata = {24'h000000, s_reg.config_bits};
        `SILM_OFS_OUT_EN: s_next.prdata = {24'h000000, s_reg.out_en};
        `SILM_OFS_IRQ_STAT: s_next.prdata = {30'h00000000, s_reg.ev_stat};
        `SILM_OFS_IRQ_MASK: s_next.prdata = {30'h00000000, s_reg.ev_mask};
        default: s_next.pslverr = 1'b1;
      endcase
    end else if (setup && PWRITE) begin
      case (PADDR)
        `SILM_OFS_STATUS: s_next.pslverr = 1'b0;
        `SILM_OFS_STICKY, `SILM_OFS_IRQ_EN, `SILM_OFS_CONFIG,
        `SILM_OFS_OUT_EN, `SILM_OFS_IRQ_CLR, `SILM_OFS_IRQ_MASK: s_next.pslverr = 1'b0;
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (wr && s_reg.pready) begin
      case (PADDR)
        `SILM_OFS_STICKY: s_next.clr = PWDATA[7:0];
        `SILM_OFS_IRQ_EN: s_next.irq_enable = PWDATA[7:0];
        `SILM_OFS_CONFIG: s_next.config_bits = PWDATA[7:0];
        `SILM_OFS_OUT_EN: s_next.out_en = PWDATA[7:0];
        `SILM_OFS_IRQ_MASK: s_next.ev_mask = PWDATA[1:0];
        `SILM_OFS_IRQ_CLR: s_next.ev_stat = s_reg.ev_stat & ~PWDATA[1:0];
        default: s_next.clr = 8'h00;
      endcase
    end
    if (wr && s_reg.pready) begin
      s_next.ev_stat[`SILM_EV_WRITE] = 1'b1;
    end
    if (|enabled_hits) begin
      s_next.ev_stat[`SILM_EV_STICKY] = 1'b1;
    end
    s_next.irq_n = ~(|enabled_hits);
    s_next.irq = |(s_next.ev_stat & s_reg.ev_mask);
    s_next.determ = !s_reg.config_bits[`SILM_CFG_FIRST_PLL_BYPASS_BIT] &&
                    s_reg.config_bits[`SILM_CFG_SYNTH_PLL_BYPASS_BIT];
    if (!(access && s_reg.pready)) begin
      s_next.pready = setup;
    end else begin
      s_next.pready = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_reg <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
                 irq_enable: `SILM_RST_IRQ_EN, config_bits: `SILM_RST_CONFIG,
                 out_en: `SILM_RST_OUT_EN, clr: 8'h00, ev_stat: 2'h0,
                 ev_mask: 2'h0, irq_n: 1'b1, irq: 1'b0, determ: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign IRQ_OUT_N = s_reg.irq_n;
  assign LOCK = lock_q;
  assign DETERMINISTIC = s_reg.determ;
  assign CLOCK_OUTPUTS_EN = s_reg.out_en[3:0];
  assign SYSREF_OUTPUTS_EN = s_reg.out_en[7:4];
  assign IRQ = s_reg.irq;

  a_irq_follows: assert property (@(posedge CLK) disable iff (RST)
    (|enabled_hits) |=> !IRQ_OUT_N) else $error("irq not asserted");
  a_irq_release: assert property (@(posedge CLK) disable iff (RST)
    !(|enabled_hits) |=> IRQ_OUT_N) else $error("irq not released");
  a_ready_one: assert property (@(posedge CLK) disable iff (RST)
    setup |=> PREADY) else $error("pready late");
  a_sticky_clear: assert property (@(posedge CLK) disable iff (RST)
    (wr && PREADY && PADDR == `SILM_OFS_STICKY && PWDATA[0] && INPUT_ACTIVE[0])
    ##1 (INPUT_ACTIVE[0] && $stable(INPUT_ACTIVE[0])) |=> !sticky_view[0])
    else $error("sticky not cleared");
  a_determ_cfg: assert property (@(posedge CLK) disable iff (RST)
    (s_reg.config_bits[2:1] == 2'b10) |=> DETERMINISTIC) else $error("determ wrong");
  c_irq: cover property (@(posedge CLK) disable iff (RST) $fell(IRQ_OUT_N));
  c_lock: cover property (@(posedge CLK) disable iff (RST) $rose(LOCK));
  c_clear: cover property (@(posedge CLK) disable iff (RST) $fell(sticky_view[0]));
endmodule : silm_top

// ### silm_defs.svh
`ifndef SILM_DEFS_SVH
`define SILM_DEFS_SVH
`define SILM_OFS_STATUS 12'h000
`define SILM_OFS_STICKY 12'h004
`define SILM_OFS_IRQ_EN 12'h008
`define SILM_OFS_CONFIG 12'h00C
`define SILM_OFS_OUT_EN 12'h010
`define SILM_OFS_IRQ_STAT 12'h014
`define SILM_OFS_IRQ_CLR 12'h018
`define SILM_OFS_IRQ_MASK 12'h01C
`define SILM_NUM_STICKY 8
`define SILM_RST_STICKY 8'h00
`define SILM_RST_IRQ_EN 8'h00
`define SILM_RST_CONFIG 8'h00
`define SILM_RST_OUT_EN 8'h00
`define SILM_CFG_MASK_BIT 0
`define SILM_CFG_FIRST_PLL_BYPASS_BIT 1
`define SILM_CFG_SYNTH_PLL_BYPASS_BIT 2
`define SILM_CFG_MODE_LSB 3
`define SILM_EV_WRITE 0
`define SILM_EV_STICKY 1
`endif

// ### silm_pkg.sv
package silm_pkg;
  typedef enum logic [1:0] {
    SILM_MODE_MANUAL,
    SILM_MODE_SHORT_HOLD,
    SILM_MODE_AUTO_HOLD,
    SILM_MODE_AUTO
  } silm_mode_t;
endpackage : silm_pkg

// ### silm_sticky_if.sv
`timescale 1ns/100ps
`include "silm_defs.svh"
interface silm_sticky_if;
  logic [`SILM_NUM_STICKY-1:0] cond;
  logic [`SILM_NUM_STICKY-1:0] clr;
  logic [`SILM_NUM_STICKY-1:0] sticky;
  modport ctrl (output cond, output clr, input sticky);
  modport bank (input cond, input clr, output sticky);
endinterface : silm_sticky_if

// ### silm_sticky_bank.sv
`timescale 1ns/100ps
`include "silm_defs.svh"
module silm_sticky_bank
  import silm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  silm_sticky_if.bank sif
);
  typedef struct packed {
    logic [`SILM_NUM_STICKY-1:0] sticky;
  } silm_bank_state_t;
  silm_bank_state_t s_reg;
  silm_bank_state_t s_next;
  logic [`SILM_NUM_STICKY-1:0] cond_d_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cond_d_reg <= '1;
    end else begin
      cond_d_reg <= sif.cond;
    end
  end

  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < `SILM_NUM_STICKY; i++) begin
      // Fault present or changed wins over clear
      if (!sif.cond[i] || (sif.cond[i] != cond_d_reg[i])) begin
        s_next.sticky[i] = 1'b1;
      end else if (sif.clr[i]) begin
        s_next.sticky[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{sticky: `SILM_RST_STICKY};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sif.sticky = s_reg.sticky;

  a_clear_blocked: assert property (@(posedge clk) disable iff (rst)
    !sif.cond[0] |=> s_reg.sticky[0]) else $error("sticky0 cleared under fault");
endmodule : silm_sticky_bank

// ### silm_lock_gen.sv
`timescale 1ns/100ps
module silm_lock_gen
  import silm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic first_locked,
  input wire logic synth_locked,
  input wire logic mask_first,
  input wire logic first_bypass,
  output logic lock_q
);
  typedef struct packed {
    logic lock;
  } silm_lock_state_t;
  silm_lock_state_t s_reg;
  silm_lock_state_t s_next;

  always_comb begin
    s_next.lock = synth_locked && (first_locked || mask_first || first_bypass);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{lock: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lock_q = s_reg.lock;

  a_lock_needs_synth: assert property (@(posedge clk) disable iff (rst)
    !synth_locked |=> !lock_q) else $error("lock without synth lock");
  a_lock_mask: assert property (@(posedge clk) disable iff (rst)
    (synth_locked && mask_first) |=> lock_q) else $error("mask ignored");
  a_lock_bypass: assert property (@(posedge clk) disable iff (rst)
    (synth_locked && first_bypass) |=> lock_q) else $error("bypass ignored");
endmodule : silm_lock_gen

// ### silm_cond_model.sv
`timescale 1ns/100ps
module silm_cond_model (
  input wire logic clk,
  input wire logic [9:0] want,
  output logic [9:0] cond_q
);
  // Monitored conditions move only just after clock edges
  initial cond_q = 10'h27F;
  always @(posedge clk) begin
    cond_q <= want;
  end
endmodule : silm_cond_model

// ### test_status_interrupt_lock_monitor.sv
`timescale 1ns/100ps
`include "silm_defs.svh"
module test_status_interrupt_lock_monitor;
  import silm_pkg::*;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, m;
  logic pready, pslverr, irq_n, lock, determ, irq;
  logic [3:0] clk_en, sys_en;
  logic [9:0] want = 10'h27F, cond;
  logic [12:0] refs [8] = '{13'h007E, 13'h10FE, 13'h057B, 13'h09B7, 13'h19F7, 13'h0870, 13'h1C32,
    13'h0C70};
  int bad_count = 0, n_compared = 0;
  initial forever #20 clk = ~clk;
  silm_cond_model silm_cond_model_inst (.clk(clk), .want(want), .cond_q(cond));
  silm_top silm_top_inst (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INPUT_ACTIVE(cond[3:0]), .FIRST_PLL_LOCKED(cond[4]), .SYNTH_PLL_LOCKED(cond[5]),
    .NOT_HOLDOVER(cond[6]), .VCO_CAL_PENDING(cond[9]), .ACTIVE_INPUT_INDEX(cond[8:7]),
    .IRQ_OUT_N(irq_n), .LOCK(lock), .DETERMINISTIC(determ), .CLOCK_OUTPUTS_EN(clk_en),
    .SYSREF_OUTPUTS_EN(sys_en), .IRQ(irq));
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      bad_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'h0, 32'h0);
    check(what, rd, exp);
  endtask : rdc
  task automatic set_cond(input logic [9:0] v);
    want <= v;
    tick(3);
  endtask : set_cond
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    tick(2);
    check("irq_n after reset", irq_n, 32'h1);
    check("outputs after reset", {sys_en, clk_en}, 32'h0);
    rdc(`SILM_OFS_IRQ_EN, 32'h0, "irq_en");
    rdc(`SILM_OFS_CONFIG, 32'h0, "config");
    rdc(`SILM_OFS_OUT_EN, 32'h0, "out_en");
    check("slverr mapped", err, 32'h0);
    wr(`SILM_OFS_STICKY, 32'hFF);
    rdc(`SILM_OFS_STICKY, 32'h0, "sticky cleared");
    rdc(`SILM_OFS_STATUS, 32'h4FF, "status vco pending");
    wr(`SILM_OFS_STATUS, 32'h0);
    rdc(`SILM_OFS_STATUS, 32'h4FF, "status after write");
    set_cond(10'h07F);
    rdc(`SILM_OFS_STATUS, 32'h0FF, "status vco done");
    for (int i = 0; i < 7; i++) begin
      m = (i == 0) ? 32'h81 : (32'h1 << i);
      set_cond(10'h07F & ~(10'h1 << i));
      rdc(`SILM_OFS_STATUS, 32'h0FF ^ m, "status fault");
      rdc(`SILM_OFS_STICKY, m, "sticky set");
      check("irq_n masked", irq_n, 32'h1);
      wr(`SILM_OFS_IRQ_EN, 32'h1 << i);
      tick(2);
      check("irq_n enabled", irq_n, 32'h0);
      wr(`SILM_OFS_STICKY, 32'hFF);
      rdc(`SILM_OFS_STICKY, m, "sticky persists");
      set_cond(10'h07F);
      rdc(`SILM_OFS_STICKY, m, "sticky held");
      check("irq_n held", irq_n, 32'h0);
      wr(`SILM_OFS_STICKY, 32'hFF);
      tick(3);
      check("irq_n released", irq_n, 32'h1);
      rdc(`SILM_OFS_STICKY, 32'h0, "sticky clear");
      wr(`SILM_OFS_IRQ_EN, 32'h0);
    end
    set_cond(10'h07D);
    wr(`SILM_OFS_IRQ_EN, 32'h2);
    wr(`SILM_OFS_IRQ_MASK, 32'h0);
    tick(2);
    check("irq masked", irq, 32'h0);
    wr(`SILM_OFS_IRQ_MASK, 32'h2);
    tick(2);
    check("irq raised", irq, 32'h1);
    set_cond(10'h07F);
    wr(`SILM_OFS_STICKY, 32'hFF);
    wr(`SILM_OFS_IRQ_CLR, 32'h3);
    apb(`SILM_OFS_IRQ_STAT, 1'h0, 32'h0);
    check("irq_stat cleared", rd & 32'h2, 32'h0);
    check("irq dropped", irq, 32'h0);
    wr(`SILM_OFS_IRQ_EN, 32'h0);
    foreach (refs[j]) begin
      wr(`SILM_OFS_CONFIG, {27'h0, refs[j][11:10], 3'h0});
      set_cond(refs[j][9:0]);
      apb(`SILM_OFS_STATUS, 1'h0, 32'h0);
      check("reference valid", rd[7], {31'h0, refs[j][12]});
    end
    for (int k = 0; k < 32; k++) begin
      wr(`SILM_OFS_CONFIG, {29'h0, k[2:0]});
      set_cond({3'h0, 1'h1, k[4], k[3], 4'hF});
      check("lock", lock, {31'h0, k[4] & (k[3] | k[0] | k[1])});
      check("deterministic", determ, {31'h0, ~k[1] & k[2]});
    end
    wr(`SILM_OFS_OUT_EN, 32'hA5);
    tick(1);
    check("output enables", {sys_en, clk_en}, 32'hA5);
    apb(12'h040, 1'h0, 32'h0);
    check("slverr unmapped", err, 32'h1);
    finish_test();
  end
endmodule : test_status_interrupt_lock_monitor
